// File: rtl/sioe_core.sv
// Purpose: Digital core of an SPI GPIO expander with change interrupt.
// Assumes: SPI mode 0 on its own clock; pins asynchronous to sys_clk_i.
// Notes: Read data comes from a snapshot frozen while chip select is low.
`timescale 1ns/1ps

module sioe_core #(
  parameter int NPORTS = sioe_pkg::NPORTS_DEF
) (
  input wire logic sys_clk_i,                          // 40 MHz core clock
  input wire logic rst_i,                              // Power-on reset
  input wire logic spi_sclk_i,                         // Link clock
  input wire logic spi_cs_n_i,                         // Chip select
  input wire logic spi_sdi_i,                          // Serial in
  output logic spi_sdo_o,                              // Serial out
  input wire logic reset_pin_n_i,                      // Reset / fail-safe pin
  input wire logic [NPORTS*sioe_pkg::PORT_W-1:0] pin_i,
  output logic [NPORTS*sioe_pkg::PORT_W-1:0] high_side_driver_o,
  output logic [NPORTS*sioe_pkg::PORT_W-1:0] low_side_driver_o,
  output logic irq_n_o,                                // Open-drain level
  output logic irq_oe_o,                               // High pulls line low
  output logic failsafe_active_o                       // Fail-safe engaged
);

  localparam int W = NPORTS * sioe_pkg::PORT_W;
  localparam int IRQ_CYC = sioe_pkg::IRQ_VALID_CYC;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte of a port vector; zero past the last port
  function automatic logic [7:0] port_byte(input logic [W-1:0] v, input logic [7:0] p);
    port_byte = 8'h00;
    for (int i = 0; i < NPORTS; i++) begin
      if (p == 8'(i)) begin
        port_byte = v[i*8 +: 8];
      end
    end
  endfunction : port_byte

  // Vector with one port byte replaced; bad port leaves it alone
  function automatic logic [W-1:0] set_byte(input logic [W-1:0] v, input logic [7:0] p,
                                            input logic [7:0] d);
    set_byte = v;
    for (int i = 0; i < NPORTS; i++) begin
      if (p == 8'(i)) begin
        set_byte[i*8 +: 8] = d;
      end
    end
  endfunction : set_byte

  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  logic [15:0] cnt;          // Bits received this frame
  logic [14:0] shift;        // Last bits received
  logic hdr_rw;              // Frame is a read
  logic [6:0] hdr_feat;      // Feature of this frame
  logic [7:0] hdr_port;      // Starting port
  logic wr_tgl;              // Flips once per written byte
  logic [6:0] wr_feat;       // Held write word
  logic [7:0] wr_port;
  logic [7:0] wr_data;
  logic rd_tgl;              // Flips once per read header
  logic [6:0] rd_feat;
  logic link_rst;            // Core reset seen by link toggles

  // ----------------------------------------------------------------
  // Core domain state
  // ----------------------------------------------------------------
  logic [W-1:0] pin_meta, pin_sync;     // Pin synchroniser
  logic rpin_meta, rpin_sync;           // Reset pin synchroniser
  logic cs_meta, cs_sync;               // Chip select synchroniser
  logic wr_meta, wr_sync, wr_seen;      // Write toggle crossing
  logic rd_meta, rd_sync, rd_seen;      // Read toggle crossing
  logic [W-1:0] dir, out, pol, mask;    // Port configuration
  logic [W-1:0] input_latch;            // Input register reference
  logic [7:0] cfga, cfgb;               // Redundant configuration
  logic fs_en;                          // Fail-safe enable
  logic [sioe_pkg::FAULT_W-1:0] fault;  // Sticky fault flags
  logic swrst;                          // Software reset pulse
  logic rst_d;                          // Reset one cycle ago
  // Snapshot read by the link; only changes while chip select is high
  logic [W-1:0] snap_in, snap_out, snap_dir, snap_pol, snap_mask, snap_flag;
  logic [sioe_pkg::FAULT_W-1:0] snap_fault;
  logic [7:0] snap_cfga, snap_cfgb;
  logic snap_fsen;

  // ----------------------------------------------------------------
  // Link decode
  // ----------------------------------------------------------------
  wire [15:0] data_bits = cnt - sioe_pkg::CNT_HDR;        // Bits into data
  // Port sum kept wide so a very long burst never wraps back to port 0
  wire [13:0] port_sum = {6'h00, hdr_port} + {1'b0, data_bits[15:3]};
  wire [7:0] cur_port = (port_sum > 14'h00ff) ? 8'hff : port_sum[7:0];  // Burst port
  wire hdr_done = (cnt == sioe_pkg::CNT_HDR_LAST);          // Header ends now
  wire byte_done = (cnt >= sioe_pkg::CNT_HDR) && (data_bits[2:0] == 3'h7);
  wire [7:0] rx_byte = {shift[6:0], spi_sdi_i};
  wire [15:0] status_word = {sioe_pkg::STATUS_TAG, snap_fault, 8'h00};
  wire single_ok = (cur_port == 8'h00);                     // One-byte features
  // Read mux; burst moves only the port, never the feature
  wire [7:0] rd_byte =
    (hdr_feat == sioe_pkg::FEAT_INPUT) ? port_byte(snap_in, cur_port) :
    (hdr_feat == sioe_pkg::FEAT_OUTPUT) ? port_byte(snap_out, cur_port) :
    (hdr_feat == sioe_pkg::FEAT_DIR) ? port_byte(snap_dir, cur_port) :
    (hdr_feat == sioe_pkg::FEAT_POL) ? port_byte(snap_pol, cur_port) :
    (hdr_feat == sioe_pkg::FEAT_MASK) ? port_byte(snap_mask, cur_port) :
    (hdr_feat == sioe_pkg::FEAT_IFLAG) ? port_byte(snap_flag, cur_port) :
    (hdr_feat == sioe_pkg::FEAT_FAULT && single_ok) ? {2'h0, snap_fault} :
    (hdr_feat == sioe_pkg::FEAT_FSEN && single_ok) ? {7'h00, snap_fsen} :
    (hdr_feat == sioe_pkg::FEAT_CFGA && single_ok) ? snap_cfga :
    (hdr_feat == sioe_pkg::FEAT_CFGB && single_ok) ? snap_cfgb :
    8'h00;                         // Reset register is write-only
  wire next_sdo = (cnt < sioe_pkg::CNT_HDR) ? status_word[4'hf - cnt[3:0]]
                                            : rd_byte[3'h7 - data_bits[2:0]];

  // ----------------------------------------------------------------
  // Link shifter
  // ----------------------------------------------------------------
  // Chip select high holds the frame logic in reset
  always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      cnt <= 16'h0000;
      shift <= 15'h0000;
      hdr_rw <= 1'b0;
      hdr_feat <= 7'h00;
      hdr_port <= 8'h00;
    end else begin
      // Saturate so very long bursts keep reading zeros
      if (cnt != sioe_pkg::CNT_MAX) begin
        cnt <= cnt + 16'h0001;
      end
      shift <= {shift[13:0], spi_sdi_i};
      if (hdr_done) begin
        hdr_rw <= shift[14];
        hdr_feat <= shift[13:7];
        hdr_port <= rx_byte;
      end
    end
  end

  // Serial out changes on the falling edge, first status bit preset
  always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      spi_sdo_o <= 1'b1;
    end else begin
      spi_sdo_o <= next_sdo;
    end
  end

  // ----------------------------------------------------------------
  // Link events toward the core
  // ----------------------------------------------------------------
  // Words are held until the next byte, far longer than the crossing
  always_ff @(posedge spi_sclk_i or posedge link_rst) begin
    if (link_rst) begin
      wr_tgl <= 1'b0;
      wr_feat <= 7'h00;
      wr_port <= 8'h00;
      wr_data <= 8'h00;
      rd_tgl <= 1'b0;
      rd_feat <= 7'h00;
    end else begin
      // Completed byte of a write frame
      if (byte_done && !hdr_rw) begin
        wr_feat <= hdr_feat;
        wr_port <= cur_port;
        wr_data <= rx_byte;
        wr_tgl <= ~wr_tgl;
      end
      // Read header complete: flag clears follow this edge
      if (hdr_done && shift[14]) begin
        rd_feat <= shift[13:7];
        rd_tgl <= ~rd_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core resets
  // ----------------------------------------------------------------
  wire hw_rst = !rpin_sync && !fs_en;
  wire hard_rst = rst_i || hw_rst;
  wire sys_rst = hard_rst || swrst;
  wire failsafe_force = fs_en && !rpin_sync;
  wire wr_evt = wr_sync ^ wr_seen;
  wire rd_evt = rd_sync ^ rd_seen;
  wire [W-1:0] pend = ~dir & ~mask & (pin_sync ^ input_latch);
  wire cfg_bad = (cfga != cfgb);
  wire [sioe_pkg::FAULT_W-1:0] fault_set = {{(sioe_pkg::FAULT_W-2){1'b0}},
                                            failsafe_force, cfg_bad};
  wire fault_clr = rd_evt && (rd_feat == sioe_pkg::FEAT_FAULT);
  wire latch_load = rd_evt && (rd_feat == sioe_pkg::FEAT_IFLAG ||
                               rd_feat == sioe_pkg::FEAT_INPUT);
  wire [W-1:0] eff_dir = dir & {W{!failsafe_force}};

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Pins run through reset so the reload at release sees real levels
  always_ff @(posedge sys_clk_i) begin
    pin_meta <= pin_i;
    pin_sync <= pin_meta;
  end

  // Reset pin and chip select; first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rpin_meta <= 1'b1;
      rpin_sync <= 1'b1;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
    end else begin
      rpin_meta <= reset_pin_n_i;
      rpin_sync <= rpin_meta;
      cs_meta <= spi_cs_n_i;
      cs_sync <= cs_meta;
    end
  end

  // Toggle crossings; cleared with the link toggles
  always_ff @(posedge sys_clk_i) begin
    if (hard_rst || link_rst) begin
      wr_meta <= 1'b0;
      wr_sync <= 1'b0;
      wr_seen <= 1'b0;
      rd_meta <= 1'b0;
      rd_sync <= 1'b0;
      rd_seen <= 1'b0;
    end else begin
      wr_meta <= wr_tgl;
      wr_sync <= wr_meta;
      wr_seen <= wr_sync;
      rd_meta <= rd_tgl;
      rd_sync <= rd_meta;
      rd_seen <= rd_sync;
    end
  end

  // Reset delay, link reset and software reset pulse
  always_ff @(posedge sys_clk_i) begin
    rst_d <= sys_rst;
    link_rst <= hard_rst;
    if (hard_rst) begin
      swrst <= 1'b0;
    end else begin
      swrst <= wr_evt && (wr_feat == sioe_pkg::FEAT_SWRST) &&
               wr_data[sioe_pkg::SWRST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      dir <= {NPORTS{sioe_pkg::DIR_RST}};
      out <= {NPORTS{sioe_pkg::OUT_RST}};
      pol <= {NPORTS{sioe_pkg::POL_RST}};
      mask <= {NPORTS{sioe_pkg::MASK_RST}};
      cfga <= sioe_pkg::CFG_RST;
      cfgb <= sioe_pkg::CFG_RST;
    end else if (wr_evt) begin
      case (wr_feat)
        sioe_pkg::FEAT_DIR: dir <= set_byte(dir, wr_port, wr_data);
        sioe_pkg::FEAT_OUTPUT: out <= set_byte(out, wr_port, wr_data);
        sioe_pkg::FEAT_POL: pol <= set_byte(pol, wr_port, wr_data);
        sioe_pkg::FEAT_MASK: mask <= set_byte(mask, wr_port, wr_data);
        sioe_pkg::FEAT_CFGA: cfga <= wr_data;
        sioe_pkg::FEAT_CFGB: cfgb <= wr_data;
        default: ;                                     // Read-only, unknown, or written elsewhere (fail-safe enable, reset)
      endcase
    end
  end

  // Fail-safe enable; a config mismatch clears it even against a write
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst || cfg_bad) begin
      fs_en <= 1'b0;
    end else if (wr_evt && wr_feat == sioe_pkg::FEAT_FSEN) begin
      fs_en <= wr_data[sioe_pkg::FSEN_BIT];
    end
  end

  // Sticky faults; a new fault wins over a clearing read
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      fault <= '0;
    end else begin
      fault <= (fault_clr ? '0 : fault) | fault_set;
    end
  end

  // ----------------------------------------------------------------
  // Input register and interrupt
  // ----------------------------------------------------------------
  // Reference latch: reloaded on reset release and on input or flag register reads
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      input_latch <= '0;
    end else if (rst_d || latch_load) begin
      input_latch <= pin_sync;
    end
  end

  // Drivers and interrupt line, all registered
  always_ff @(posedge sys_clk_i) begin
    irq_n_o <= 1'b0;                                   // Open drain pulls low only
    if (sys_rst) begin
      high_side_driver_o <= '0;
      low_side_driver_o <= '0;
      irq_oe_o <= 1'b0;
      failsafe_active_o <= 1'b0;
    end else begin
      high_side_driver_o <= eff_dir & out;
      low_side_driver_o <= eff_dir & ~out;
      irq_oe_o <= (|pend) || (|fault);
      failsafe_active_o <= failsafe_force;
    end
  end

  // ----------------------------------------------------------------
  // Read snapshot
  // ----------------------------------------------------------------
  // Frozen while chip select is low so the link reads stable words
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      snap_in <= '0;
      snap_out <= '0;
      snap_dir <= '0;
      snap_pol <= '0;
      snap_mask <= '0;
      snap_flag <= '0;
      snap_fault <= '0;
      snap_cfga <= 8'h00;
      snap_cfgb <= 8'h00;
      snap_fsen <= 1'b0;
    end else if (cs_sync) begin
      snap_in <= pin_sync ^ pol;
      snap_out <= out;
      snap_dir <= dir;
      snap_pol <= pol;
      snap_mask <= mask;
      snap_flag <= pend;
      snap_fault <= fault;
      snap_cfga <= cfga;
      snap_cfgb <= cfgb;
      snap_fsen <= fs_en;
    end
  end

  // ----------------------------------------------------------------
  // Checks, core domain
  // ----------------------------------------------------------------
  sequence s_flag_read;
    rd_evt && rd_feat == sioe_pkg::FEAT_IFLAG;
  endsequence

  sequence s_pins_still;
    $stable(pin_sync) ##0 !sys_rst;
  endsequence

  a_reset_inputs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (hw_rst || swrst) |=> (high_side_driver_o == '0 && low_side_driver_o == '0))
    else $error("drivers on after reset");
  a_dir_drives: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!sys_rst && !failsafe_force) |=> ((high_side_driver_o | low_side_driver_o) == $past(dir)))
    else $error("drivers do not follow direction");
  a_driver_excl: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (high_side_driver_o & low_side_driver_o) == '0)
    else $error("both drivers on");
  a_pol_input: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cs_sync |=> (snap_in == ($past(pin_sync) ^ $past(pol))))
    else $error("input polarity wrong");
  a_irq_valid: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (|pend && !sys_rst) |-> ##[1:IRQ_CYC] irq_oe_o)
    else $error("interrupt late");
  a_out_no_irq: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (((~dir & ~mask) == '0) && fault == '0 && !sys_rst) |=> !irq_oe_o)
    else $error("output pin interrupted");
  a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_flag_read ##1 s_pins_still |-> (pend == '0))
    else $error("flag read did not clear");
  a_swrst_dflt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    swrst |=> (dir == '0 && mask == {NPORTS{sioe_pkg::MASK_RST}}))
    else $error("software reset missed");
  a_cfg_fault: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg_bad && !sys_rst) ##1 !sys_rst |-> !fs_en ##1 irq_oe_o)
    else $error("config mismatch not flagged");
  a_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(sys_rst) |=> (input_latch == $past(pin_sync)))
    else $error("input not reloaded");

  // ----------------------------------------------------------------
  // Checks, link domain
  // ----------------------------------------------------------------
  a_status_zero: assert property (@(posedge spi_sclk_i) disable iff (spi_cs_n_i)
    (cnt >= sioe_pkg::CNT_STAT_ZERO && cnt < sioe_pkg::CNT_HDR) |-> !spi_sdo_o)
    else $error("status tail not zero");
  a_burst_zero: assert property (@(posedge spi_sclk_i) disable iff (spi_cs_n_i)
    (cnt > sioe_pkg::CNT_HDR && cur_port >= 8'(NPORTS)) |-> !spi_sdo_o)
    else $error("data past last port");
  a_feat_fixed: assert property (@(posedge spi_sclk_i) disable iff (spi_cs_n_i)
    (cnt > sioe_pkg::CNT_HDR) |-> $stable(hdr_feat))
    else $error("burst changed feature");

endmodule : sioe_core

// File: rtl/sioe_pkg.sv
// Purpose: Shared constants for the SPI GPIO expander core.
// Assumes: Mode-0 serial link, up to three eight-bit ports.
// Notes: Feature codes sit in header bits 14..8; bit 15 selects read.
// Function
// - All pins input after any reset.
// - Direction register sets each pin's direction.
// - Polarity bit inverts pin in input register.
// - All registers readable except write-only reset.
// - Output bit picks high or low driver.
// - Interrupt low while input differs from register.
// - Input edge interrupts only when pin unmasked.
// - Flag read or return-to-level clears interrupt.
// - Later changes after clear interrupt again.
// - Output pins and foreign traffic never interrupt.
// - Output-to-input switch may interrupt spuriously.
// - Reset pin low forces all defaults.
// - Reset release reloads input register from pins.
// - Reset frame with data bit 1 resets registers.
// - Fail-safe bit 0 repurposes reset pin.
// - Faults clear fail-safe enable and interrupt; only the config mismatch fault clears the enable here.
// - Mismatched redundant configuration registers raise interrupt.
// - Burst read advances port after each byte.
// - Past last port, shift out zeros only.
// - Burst never crosses into another feature.
// - Sample rising, shift falling, MSB first.
// - Chip select high ignores clock and data.
// - First frame bit selects write or read.
// - First sixteen clocks carry status word.

package sioe_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;            // Bits per port
  localparam int NPORTS_DEF = 3;        // Ports on the largest variant
  localparam int FAULT_W = 6;           // Fault bits in status word
  localparam int FAULT_CFG = 0;         // Redundant config mismatch
  localparam int FAULT_FS = 1;          // Fail-safe pin tripped
  localparam int SWRST_BIT = 1;         // Data bit that fires reset
  localparam int FSEN_BIT = 0;          // Fail-safe enable bit

  // ----------------------------------------------------------------
  // Frame layout, counted in received bits
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_HDR_LAST = 16'h000f; // Last header bit
  localparam logic [15:0] CNT_HDR = 16'h0010;      // First data bit
  localparam logic [15:0] CNT_STAT_ZERO = 16'h0008; // Zero tail of status
  localparam logic [15:0] CNT_MAX = 16'hffff;      // Counter saturates
  localparam logic [1:0] STATUS_TAG = 2'h3;        // Status segment tag

  // ----------------------------------------------------------------
  // Feature codes
  // ----------------------------------------------------------------
  localparam logic [6:0] FEAT_INPUT = 7'h01;
  localparam logic [6:0] FEAT_OUTPUT = 7'h03;
  localparam logic [6:0] FEAT_DIR = 7'h04;
  localparam logic [6:0] FEAT_POL = 7'h05;
  localparam logic [6:0] FEAT_MASK = 7'h06;
  localparam logic [6:0] FEAT_IFLAG = 7'h07;
  localparam logic [6:0] FEAT_FAULT = 7'h08;
  localparam logic [6:0] FEAT_FSEN = 7'h09;
  localparam logic [6:0] FEAT_CFGA = 7'h0a;
  localparam logic [6:0] FEAT_CFGB = 7'h0b;
  localparam logic [6:0] FEAT_SWRST = 7'h1a;

  // ----------------------------------------------------------------
  // Reset values per port byte
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RST = 8'h00;    // All inputs
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;   // All masked
  localparam logic [7:0] CFG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;          // 40 MHz system clock
  localparam int IRQ_VALID_DELAY_NS = 200;    // Longest pin-to-irq time
  localparam int IRQ_VALID_CYC = IRQ_VALID_DELAY_NS / CLK_PERIOD_NS;

endpackage : sioe_pkg

// File: sim/sioe_spim.sv
// Purpose: SPI mode-0 controller model for the expander core
// Assumes: 64 ns link clock, parked low between frames
// Notes: Captures sdo on each rise into rx_o, MSB first
`timescale 1ns/1ps
module sioe_spim (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  output logic [47:0] rx_o,
  output logic done_o
);
  // Idle bus: clock stopped, chip deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    rx_o = '0;
    done_o = 1'b0;
  end
  // One frame of the top n bits of tx; bit 47 picks read or write
  task automatic xfer(input logic [47:0] tx, input int n);
    rx_o = '0;
    cs_n_o = 1'b0;
    #150;
    for (int i = 47; i >= 48 - n; i--) begin
      sdi_o = tx[i];
      #32 sclk_o = 1'b1;
      rx_o = {rx_o[46:0], sdo_i};
      #32 sclk_o = 1'b0;
    end
    #60 cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Released line must not hold a stale bit
    done_o = ~done_o;
    #250;
  endtask : xfer
endmodule : sioe_spim

// File: sim/tb_sioe_core.sv
// Purpose: Self-checking bench for the expander core
// Assumes: Pins and reset pin driven on falling sys_clk_i
// Notes: Frame results scored from a queue of expected words
`timescale 1ns/1ps
module tb_sioe_core;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rpin_n = 1'b1;
  logic [23:0] pin = '0;
  logic [31:0] seed = 32'h000065e7;
  logic [47:0] q [$];
  logic [7:0] r;
  wire sclk, cs_n, sdi, sdo, irq_n, irq_oe, fs, done;
  wire [47:0] rx;
  wire [23:0] hs, ls;
  int miscompares = 0;
  int n_tests = 0;
  localparam logic [15:0] ST = 16'hc000; // Status word, no faults
  localparam logic [15:0] STF = 16'hc100; // Status word, config fault
  sioe_core sioe_core_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .reset_pin_n_i(rpin_n),
    .pin_i(pin), .high_side_driver_o(hs), .low_side_driver_o(ls), .irq_n_o(irq_n),
    .irq_oe_o(irq_oe), .failsafe_active_o(fs));
  sioe_spim sioe_spim_i (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
    .rx_o(rx), .done_o(done));
  always #12.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (q.size() != 0) begin
      miscompares++; // Frames that never finished
    end
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // Note the expectation, then run the frame
  task automatic fr(input logic [47:0] tx, input int n, input logic [47:0] e);
    q.push_back(e);
    sioe_spim_i.xfer(tx, n);
    @(negedge sys_clk_i); // Pins change on the falling edge only
  endtask : fr
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : wt
  // Scoreboard: oldest note against each finished frame
  always @(done) if (q.size() != 0) chk(rx, q.pop_front());
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    wt(5);
    rst_i = 1'b0;
    wt(6);
    chk({hs, ls}, '0);
    fr({1'b0, sioe_pkg::FEAT_POL, 8'h01, 8'hff, 24'h0}, 24, {24'h0, ST, 8'h00});
    seed = xs(seed);
    pin = seed[23:0];
    wt(4);
    fr({1'b1, sioe_pkg::FEAT_INPUT, 8'h00, 32'h0}, 48,
      {ST, pin[7:0], ~pin[15:8], pin[23:16], 8'h00});
    fr({1'b0, sioe_pkg::FEAT_MASK, 16'h00fe, 24'h0}, 24, {24'h0, ST, 8'hff});
    pin[1] = ~pin[1];
    wt(10);
    chk(48'(irq_oe), 48'h0);
    pin[1] = ~pin[1];
    pin[0] = ~pin[0];
    wt(10);
    chk(48'(irq_oe), 48'h1);
    fr({1'b1, sioe_pkg::FEAT_IFLAG, 16'h0, 24'h0}, 24, {24'h0, ST, 8'h01});
    chk(48'(irq_oe), 48'h0);
    pin[0] = ~pin[0];
    wt(10);
    chk(48'(irq_oe), 48'h1);
    pin[0] = ~pin[0];
    wt(10);
    chk(48'(irq_oe), 48'h0);
    seed = xs(seed);
    r = seed[7:0];
    fr({1'b0, sioe_pkg::FEAT_DIR, 16'h00ff, 24'h0}, 24, {24'h0, ST, 8'h00});
    fr({1'b0, sioe_pkg::FEAT_OUTPUT, 8'h00, r, 24'h0}, 24, {24'h0, ST, 8'h00});
    chk({hs, ls}, {16'h0, r, 16'h0, ~r});
    pin[0] = ~pin[0];
    wt(10);
    chk(48'(irq_oe), 48'h0);
    rpin_n = 1'b0;
    wt(6);
    chk({hs, ls}, '0);
    rpin_n = 1'b1;
    wt(6);
    fr({1'b0, sioe_pkg::FEAT_DIR, 16'h00ff, 24'h0}, 24, {24'h0, ST, 8'h00});
    fr({1'b0, sioe_pkg::FEAT_SWRST, 16'h0002, 24'h0}, 24, {24'h0, ST, 8'h00});
    chk({hs, ls}, '0);
    fr({1'b1, sioe_pkg::FEAT_DIR, 16'h0, 24'h0}, 24, {24'h0, ST, 8'h00});
    // Redundant configuration mismatch, then fault read and clear
    fr({1'b0, sioe_pkg::FEAT_CFGA, 16'h005a, 24'h0}, 24, {24'h0, ST, 8'h00});
    chk(48'(irq_oe), 48'h1);
    fr({1'b0, sioe_pkg::FEAT_CFGB, 16'h005a, 24'h0}, 24, {24'h0, STF, 8'h00});
    fr({1'b1, sioe_pkg::FEAT_FAULT, 16'h0, 24'h0}, 24, {24'h0, STF, 8'h01});
    chk(48'(irq_oe), 48'h0);
    // Fail-safe: pin low turns drivers off without resetting registers
    fr({1'b0, sioe_pkg::FEAT_DIR, 16'h00ff, 24'h0}, 24, {24'h0, ST, 8'h00});
    fr({1'b0, sioe_pkg::FEAT_FSEN, 16'h0001, 24'h0}, 24, {24'h0, ST, 8'h00});
    rpin_n = 1'b0;
    wt(6);
    chk({hs, ls}, '0);
    chk(48'(fs), 48'h1);
    chk(48'(irq_oe), 48'h1);
    rpin_n = 1'b1;
    wt(6);
    chk({hs, ls}, {24'h0, 24'h0000ff});
    chk(48'(fs), 48'h0);
    chk(48'(irq_n), 48'h0);
    summarize();
  end
endmodule : tb_sioe_core
